// ### aoc_pkg.sv
// Types for the converter output and power control block
package aoc_pkg;
    typedef enum logic [2:0] {
        CAL_WAIT_WAKE,
        CAL_DELAY,
        CAL_RUN,
        CAL_READY,
        CAL_SLEEP
    } aoc_cal_state_t;
endpackage

// ### aoc_regs.svh
// Constants for the converter output and power control block
`ifndef AOC_REGS_SVH
`define AOC_REGS_SVH
// Overview of operation
// - Interleave: one core rising, other falling
// - Interleave plus demux spreads over four buses
// - Non-demux interleave: Q older than I
// - Pin mode uses I; extended interleave selects
// - Interleave runs background sampling-phase trim
// - Demux taps: 13 and 14 cycles
// - Interleave Q taps: 13.5 and 14.5 cycles
// - Non-demux: delayed buses high impedance
// - Non-demux interleave: I 13, Q 13.5
// - Pin SDR: edge pin picks data edge
// - Extended: select bit is edge or demux
// - DDR strobe keeps zero phase with data
// - Demux DDR sync delay four, else three
// - SDR strobe at data rate, DDR half
// - Floating edge pin selects DDR
// - Swing pin or bit reduces amplitude
// - Sleep: data Hi-Z, strobe and flag low
// - Q sleep powers Q only; full sleep after power-up calibration clears pipeline valid
// - Sleep deferred past calibration; power-up delay waits wake
// - Calibration request while asleep is dropped
// - Q skipped in calibration; recalibrate later
`define AOC_PIPE_DEPTH         13
`define AOC_SYNC_DLY_BASE      3'h3
`define AOC_SYNC_DLY_DEMUX_DDR 3'h4
`define AOC_CAL_LOW_CYCLES     16'h0040
`define AOC_CAL_HIGH_CYCLES    16'h0040
`define AOC_CAL_RUN_CYCLES     16'h1000
`define AOC_PWRUP_DLY_CYCLES   16'h0400
`define AOC_TRIM_PERIOD        16'h0100
`define AOC_IDLE_BYTE          8'h00
`define AOC_RANGE_LOW          8'h00
`define AOC_RANGE_HIGH         8'hFF
`define AOC_PIN_EXT_N          0
`define AOC_PIN_EDGE           1
`define AOC_PIN_EDGE_FLOAT     2
`define AOC_PIN_SWING          3
`define AOC_PIN_DES_FLOAT      4
`define AOC_PIN_SLEEP          5
`define AOC_PIN_QSLEEP         6
`define AOC_PIN_TRIM           7
`endif

// ### aoc_rx_model.sv
// Receiver model that captures the link buses at each strobe transition
module aoc_rx_model (
    // Link side
    input  wire logic       link_clock,
    input  wire logic       resetn,
    input  wire logic       output_data_strobe,
    input  wire logic [7:0] i_primary_bus,
    input  wire logic [7:0] i_delayed_bus,
    input  wire logic [7:0] q_primary_bus,
    input  wire logic [7:0] q_delayed_bus,
    // Count of frames taken
    output int              frames
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        strobe_q;
    logic [31:0] word_q;
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            strobe_q <= 1'b0;
            frames   <= 0;
            word_q   <= 32'h0000_0000;
        end else begin
            strobe_q <= output_data_strobe;
            // Both strobe edges carry data in DDR
            if (strobe_q !== output_data_strobe) begin
                frames <= frames + 1;
                word_q <= {q_delayed_bus, i_delayed_bus,
                           q_primary_bus, i_primary_bus};
            end
        end
    end
endmodule

// ### aoc_top.sv
// Output formatting, link crossing and power/calibration control
`include "aoc_regs.svh"
module aoc_top #(
    parameter int          PIPE_DEPTH      = `AOC_PIPE_DEPTH,
    parameter logic [15:0] CAL_LOW_CYCLES  = `AOC_CAL_LOW_CYCLES,
    parameter logic [15:0] CAL_HIGH_CYCLES = `AOC_CAL_HIGH_CYCLES,
    parameter logic [15:0] CAL_RUN_CYCLES  = `AOC_CAL_RUN_CYCLES,
    parameter logic [15:0] PWRUP_CYCLES    = `AOC_PWRUP_DLY_CYCLES,
    parameter logic [15:0] TRIM_PERIOD     = `AOC_TRIM_PERIOD
) (
    // Clocks and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       clock_enable,
    input  wire logic       link_clock,
    // Samples from the two converter cores
    input  wire logic [7:0] i_core_sample,
    input  wire logic [7:0] q_core_sample,
    // Control pins, asynchronous
    input  wire logic       extended_mode_n,
    input  wire logic       output_transition_edge_pin,
    input  wire logic       edge_pin_floating,
    input  wire logic       swing_level_pin,
    input  wire logic       dual_edge_pin_floating,
    input  wire logic       sleep_pin,
    input  wire logic       q_sleep_pin,
    input  wire logic       trim_request_pin,
    // Extended-mode settings, same clock
    input  wire logic       ddr_disable_n_bit,
    input  wire logic       edge_or_demux_select,
    input  wire logic       swing_level_bit,
    input  wire logic       dual_edge_bit,
    input  wire logic       q_input_select_bit,
    // Core and analog control
    output logic            i_core_on_rising,
    output logic            q_core_on_rising,
    output logic            sampled_input_is_q,
    output logic            q_core_powered,
    output logic            phase_trim_pulse,
    output logic            reduced_swing,
    output logic [2:0]      sync_delay_cycles,
    // Status
    output logic            des_active,
    output logic            ddr_active,
    output logic            demux_active,
    output logic            power_down_active,
    output logic            calibration_busy,
    output logic            q_cal_pending,
    output logic            pipeline_valid,
    // Link outputs
    output logic [7:0]      i_primary_bus,
    output logic            i_primary_oe,
    output logic [7:0]      i_delayed_bus,
    output logic            i_delayed_oe,
    output logic [7:0]      q_primary_bus,
    output logic            q_primary_oe,
    output logic [7:0]      q_delayed_bus,
    output logic            q_delayed_oe,
    output logic            output_data_strobe,
    output logic            range_exceed_flag
);
    typedef struct packed {
        logic [7:0]                  pin_s1;
        logic [7:0]                  pin_s2;
        logic [7:0]                  pin_s3;
        logic [7:0]                  pin_st;
        logic                        ack_s1;
        logic                        ack_s2;
        logic                        ack_s3;
        logic                        ack_st;
        logic [PIPE_DEPTH:0][7:0]    i_pipe;
        logic [PIPE_DEPTH:0][7:0]    q_pipe;
        logic                        phase;
        logic                        req;
        logic [7:0]                  b_ip;
        logic [7:0]                  b_id;
        logic [7:0]                  b_qp;
        logic [7:0]                  b_qd;
        logic                        b_ddr;
        logic                        b_demux;
        logic                        b_rise;
        logic                        b_sleep;
        logic                        b_range;
        aoc_pkg::aoc_cal_state_t     state;
        logic [15:0]                 cnt;
        logic [15:0]                 low_cnt;
        logic [15:0]                 high_cnt;
        logic                        low_ok;
        logic                        q_prev;
        logic                        q_pend;
        logic                        pipe_ok;
        logic [7:0]                  fill;
        logic [15:0]                 trim_cnt;
        logic                        trim_pulse;
        logic [4:0]                  ce_run;
    } aoc_core_t;

    typedef struct packed {
        logic       req_s1;
        logic       req_s2;
        logic       req_s3;
        logic       req_st;
        logic       ack;
        logic       half;
        logic       strobe;
        logic       ddr;
        logic       rise;
        logic       sleep;
        logic       demux;
        logic       range;
        logic [7:0] ip;
        logic [7:0] id;
        logic [7:0] qp;
        logic [7:0] qd;
    } aoc_link_t;

    aoc_core_t  cq;
    aoc_core_t  cd;
    aoc_link_t  lq;
    aoc_link_t  ld;
    logic [7:0] pins;
    logic       ext;
    logic       sleep_req;
    logic       q_down;
    logic       trim_pin;
    logic       asleep;
    logic       cal_fire;
    logic       start_run;
    logic       frame_rdy;
    logic       launch;
    logic       b_over;

    assign pins = {trim_request_pin, q_sleep_pin, sleep_pin,
                   dual_edge_pin_floating, swing_level_pin,
                   edge_pin_floating, output_transition_edge_pin,
                   extended_mode_n};
    assign ext       = !cq.pin_st[`AOC_PIN_EXT_N];
    assign sleep_req = cq.pin_st[`AOC_PIN_SLEEP];
    assign q_down    = cq.pin_st[`AOC_PIN_QSLEEP];
    assign trim_pin  = cq.pin_st[`AOC_PIN_TRIM];

    assign ddr_active = ext ? !ddr_disable_n_bit
                            : cq.pin_st[`AOC_PIN_EDGE_FLOAT];
    // select bit: demux choice in DDR
    assign demux_active = !(ext && ddr_active && edge_or_demux_select);
    assign des_active   = ext ? dual_edge_bit
                              : cq.pin_st[`AOC_PIN_DES_FLOAT];
    assign sampled_input_is_q = ext && q_input_select_bit && des_active;
    assign i_core_on_rising = 1'b0;
    assign q_core_on_rising = des_active;
    assign reduced_swing = ext ? !swing_level_bit
                               : !cq.pin_st[`AOC_PIN_SWING];
    assign sync_delay_cycles = (ddr_active && demux_active)
                             ? `AOC_SYNC_DLY_DEMUX_DDR : `AOC_SYNC_DLY_BASE;
    assign q_core_powered    = !q_down && !asleep;
    assign asleep            = (cq.state == aoc_pkg::CAL_SLEEP)
                             || (cq.state == aoc_pkg::CAL_WAIT_WAKE
                                 && sleep_req);
    assign power_down_active = asleep;
    assign calibration_busy  = cq.state == aoc_pkg::CAL_RUN;
    assign q_cal_pending     = cq.q_pend;
    assign pipeline_valid    = cq.pipe_ok;
    assign phase_trim_pulse  = cq.trim_pulse;

    assign cal_fire  = (cq.state == aoc_pkg::CAL_READY) && !sleep_req
                     && cq.low_ok && trim_pin
                     && (cq.high_cnt >= CAL_HIGH_CYCLES - 16'h0001);
    assign start_run = clock_enable && (cal_fire
                     || (cq.state == aoc_pkg::CAL_DELAY && !sleep_req
                         && cq.cnt == 16'h0000));
    // Demux emits at most one frame every two input clocks
    assign frame_rdy = demux_active ? cq.phase : 1'b1;
    // New frame only once the link returned the last one
    assign launch    = clock_enable && frame_rdy && (cq.req == cq.ack_st);
    assign b_over    = (cq.i_pipe[PIPE_DEPTH-1] == `AOC_RANGE_HIGH)
                    || (cq.i_pipe[PIPE_DEPTH-1] == `AOC_RANGE_LOW)
                    || (cq.q_pipe[PIPE_DEPTH-1] == `AOC_RANGE_HIGH)
                    || (cq.q_pipe[PIPE_DEPTH-1] == `AOC_RANGE_LOW);

    always_comb begin
        cd = cq;
        if (clock_enable) begin
            cd.pin_s1 = pins;
            cd.pin_s2 = cq.pin_s1;
            cd.pin_s3 = cq.pin_s2;
            // Accept a pin level once stages two and three agree
            cd.pin_st = (~(cq.pin_s2 ^ cq.pin_s3) & cq.pin_s3)
                      | ((cq.pin_s2 ^ cq.pin_s3) & cq.pin_st);
            cd.ack_s1 = lq.ack;
            cd.ack_s2 = cq.ack_s1;
            cd.ack_s3 = cq.ack_s2;
            if (cq.ack_s2 == cq.ack_s3) begin
                cd.ack_st = cq.ack_s3;
            end
            cd.ce_run = (cq.ce_run == 5'h1F) ? cq.ce_run : cq.ce_run + 5'h01;
            // separate same-depth delay line for each core
            cd.i_pipe = {cq.i_pipe[PIPE_DEPTH-1:0], i_core_sample};
            cd.q_pipe = {cq.q_pipe[PIPE_DEPTH-1:0], q_core_sample};
            cd.phase  = !cq.phase;
            if (launch) begin
                cd.req     = !cq.req;
                // four taps, primary and one input clock older
                cd.b_ip    = cq.i_pipe[PIPE_DEPTH-1];
                cd.b_id    = cq.i_pipe[PIPE_DEPTH];
                // In interleave, Q core taps carry the half-cycle-earlier sample
                // Q byte is the older one
                cd.b_qp    = (q_down && !des_active) ? `AOC_IDLE_BYTE
                                                      : cq.q_pipe[PIPE_DEPTH-1];
                cd.b_qd    = (q_down && !des_active) ? `AOC_IDLE_BYTE
                                                      : cq.q_pipe[PIPE_DEPTH];
                cd.b_ddr   = ddr_active;
                cd.b_demux = demux_active;
                // edge select from pin or bit
                cd.b_rise  = ext ? edge_or_demux_select
                                 : cq.pin_st[`AOC_PIN_EDGE];
                cd.b_sleep = asleep;
                cd.b_range = b_over;
            end
            if (des_active) begin
                cd.trim_pulse = cq.trim_cnt == TRIM_PERIOD - 16'h0001;
                cd.trim_cnt   = cd.trim_pulse ? 16'h0000
                                              : cq.trim_cnt + 16'h0001;
            end else begin
                cd.trim_pulse = 1'b0;
                cd.trim_cnt   = 16'h0000;
            end
            // measure request low and high phases
            if (cq.state == aoc_pkg::CAL_READY && !cal_fire) begin
                if (!trim_pin) begin
                    cd.high_cnt = 16'h0000;
                    if (cq.low_cnt >= CAL_LOW_CYCLES - 16'h0001) begin
                        cd.low_ok = 1'b1;
                    end else begin
                        cd.low_cnt = cq.low_cnt + 16'h0001;
                    end
                end else if (cq.low_ok) begin
                    cd.high_cnt = cq.high_cnt + 16'h0001;
                end else begin
                    cd.low_cnt = 16'h0000;
                end
            end else begin
                // nothing queued outside the ready state
                cd.low_cnt  = 16'h0000;
                cd.high_cnt = 16'h0000;
                cd.low_ok   = 1'b0;
            end
            // refill before the pipeline counts as valid
            if (cq.fill > 8'(PIPE_DEPTH)) begin
                cd.pipe_ok = 1'b1;
            end else begin
                cd.fill = cq.fill + 8'h01;
            end
            // Q needs a fresh calibration after its sleep
            cd.q_prev = q_down;
            cd.q_pend = (start_run ? q_down : cq.q_pend)
                      | (q_down && !cq.q_prev);
            unique case (cq.state)
                aoc_pkg::CAL_WAIT_WAKE: begin
                    // power-up delay held off while asleep
                    if (!sleep_req) begin
                        cd.state = aoc_pkg::CAL_DELAY;
                        cd.cnt   = PWRUP_CYCLES;
                    end
                end
                aoc_pkg::CAL_DELAY: begin
                    if (sleep_req) begin
                        cd.state = aoc_pkg::CAL_WAIT_WAKE;
                    end else if (cq.cnt == 16'h0000) begin
                        cd.state = aoc_pkg::CAL_RUN;
                        cd.cnt   = CAL_RUN_CYCLES;
                    end else begin
                        cd.cnt = cq.cnt - 16'h0001;
                    end
                end
                aoc_pkg::CAL_RUN: begin
                    // sleep waits for the run to finish
                    if (cq.cnt == 16'h0000) begin
                        cd.state = aoc_pkg::CAL_READY;
                    end else begin
                        cd.cnt = cq.cnt - 16'h0001;
                    end
                end
                aoc_pkg::CAL_READY: begin
                    if (sleep_req) begin
                        cd.state = aoc_pkg::CAL_SLEEP;
                    end else if (cal_fire) begin
                        cd.state = aoc_pkg::CAL_RUN;
                        cd.cnt   = CAL_RUN_CYCLES;
                    end
                end
                aoc_pkg::CAL_SLEEP: begin
                    cd.fill    = 8'h00;
                    cd.pipe_ok = 1'b0;
                    if (!sleep_req) begin
                        cd.state = aoc_pkg::CAL_READY;
                    end
                end
            endcase
        end else begin
            cd.ce_run = 5'h00;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cq <= '0;
        end else begin
            cq <= cd;
        end
    end

    // Link side: handshake; bundle is stable while req is pending
    always_comb begin
        ld        = lq;
        ld.req_s1 = cq.req;
        ld.req_s2 = lq.req_s1;
        ld.req_s3 = lq.req_s2;
        if (lq.req_s2 == lq.req_s3) begin
            ld.req_st = lq.req_s3;
        end
        if (lq.req_st != lq.ack) begin
            ld.ack   = lq.req_st;
            ld.ip    = cq.b_ip;
            ld.id    = cq.b_id;
            ld.qp    = cq.b_qp;
            ld.qd    = cq.b_qd;
            ld.ddr   = cq.b_ddr;
            ld.rise  = cq.b_rise;
            ld.sleep = cq.b_sleep;
            ld.demux = cq.b_demux;
            ld.range = cq.b_range;
            ld.half  = 1'b1;
            // DDR: strobe edge with every data change
            // SDR: one strobe period per word
            ld.strobe = cq.b_ddr ? !lq.strobe : cq.b_rise;
        end else if (lq.half) begin
            ld.half = 1'b0;
            if (!lq.ddr) begin
                ld.strobe = !lq.rise;
            end
        end
        // strobe and flag held low in sleep
        if (ld.sleep) begin
            ld.strobe = 1'b0;
            ld.range  = 1'b0;
        end
    end

    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    assign i_primary_bus      = lq.ip;
    assign i_delayed_bus      = lq.id;
    assign q_primary_bus      = lq.qp;
    assign q_delayed_bus      = lq.qd;
    assign output_data_strobe = lq.strobe;
    assign range_exceed_flag  = lq.range;
    assign i_primary_oe       = !lq.sleep;
    assign q_primary_oe       = !lq.sleep;
    assign i_delayed_oe       = !lq.sleep && lq.demux;
    assign q_delayed_oe       = !lq.sleep && lq.demux;

    a_des_opposite_edges: assert property (
        @(posedge clock) disable iff (!resetn)
        des_active |-> (i_core_on_rising != q_core_on_rising))
        else $error("interleave cores on same edge");
    a_demux_frame_rate: assert property (
        @(posedge clock) disable iff (!resetn)
        (launch && demux_active) |=> !launch)
        else $error("demux frames back to back");
    a_pin_mode_input: assert property (
        @(posedge clock) disable iff (!resetn)
        !ext |-> !sampled_input_is_q)
        else $error("pin mode sampled Q input");
    a_trim_idle: assert property (
        @(posedge clock) disable iff (!resetn)
        (!des_active && clock_enable) |=> !phase_trim_pulse)
        else $error("phase trim outside interleave");
    a_primary_latency: assert property (
        @(posedge clock) disable iff (!resetn)
        (launch && cq.ce_run >= 5'h0D)
        |=> cq.b_ip == $past(i_core_sample, 14))
        else $error("primary tap latency wrong");
    a_delayed_latency: assert property (
        @(posedge clock) disable iff (!resetn)
        (launch && cq.ce_run >= 5'h0E && !q_down)
        |=> cq.b_qd == $past(q_core_sample, 15))
        else $error("delayed tap latency wrong");
    a_sleep_deferred: assert property (
        @(posedge clock) disable iff (!resetn)
        (calibration_busy && cq.cnt != 16'h0000 && clock_enable)
        |=> calibration_busy)
        else $error("calibration cut short");
    a_asleep_no_cal: assert property (
        @(posedge clock) disable iff (!resetn)
        (cq.state == aoc_pkg::CAL_SLEEP) |=> !calibration_busy)
        else $error("calibration started in sleep");
    a_q_cal_flag: assert property (
        @(posedge clock) disable iff (!resetn)
        (start_run && q_down) |=> q_cal_pending)
        else $error("Q skipped but no pending flag");
    a_delayed_hiz: assert property (
        @(posedge link_clock) disable iff (!resetn)
        !lq.demux |-> !(i_delayed_oe || q_delayed_oe))
        else $error("delayed bus driven in non-demux");
    a_sleep_lines: assert property (
        @(posedge link_clock) disable iff (!resetn)
        lq.sleep |-> !(output_data_strobe || range_exceed_flag
                       || i_primary_oe))
        else $error("outputs active in sleep");
    a_ddr_strobe: assert property (
        @(posedge link_clock) disable iff (!resetn)
        (lq.req_st != lq.ack && cq.b_ddr && !cq.b_sleep)
        |=> output_data_strobe != $past(output_data_strobe))
        else $error("DDR strobe missed a data edge");
    a_sdr_rise_edge: assert property (
        @(posedge link_clock) disable iff (!resetn)
        (lq.req_st != lq.ack && !cq.b_ddr && cq.b_rise && !cq.b_sleep)
        |=> output_data_strobe ##1 !output_data_strobe)
        else $error("SDR data not on rising strobe");
endmodule

// ### tb_top.sv
// Self-checking bench for the output and power control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock, resetn, clock_enable, link_clock;
    logic [7:0] i_core_sample, q_core_sample;
    logic       extended_mode_n, output_transition_edge_pin;
    logic       edge_pin_floating, swing_level_pin, dual_edge_pin_floating;
    logic       sleep_pin, q_sleep_pin, trim_request_pin;
    logic       ddr_disable_n_bit, edge_or_demux_select, swing_level_bit;
    logic       dual_edge_bit, q_input_select_bit;
    logic       i_core_on_rising, q_core_on_rising, sampled_input_is_q;
    logic       q_core_powered, phase_trim_pulse, reduced_swing;
    logic [2:0] sync_delay_cycles;
    logic       des_active, ddr_active, demux_active, power_down_active;
    logic       calibration_busy, q_cal_pending, pipeline_valid;
    logic [7:0] i_primary_bus, i_delayed_bus, q_primary_bus, q_delayed_bus;
    logic       i_primary_oe, i_delayed_oe, q_primary_oe, q_delayed_oe;
    logic       output_data_strobe, range_exceed_flag;
    logic [7:0] e;
    logic       ramp;
    logic [31:0] w;
    int         errors, samples_checked, seed, frames, n, m;

    // Short counts keep calibration runs brief
    aoc_top #(.CAL_LOW_CYCLES(16'h0004),
        .CAL_HIGH_CYCLES(16'h0004), .CAL_RUN_CYCLES(16'h0010),
        .PWRUP_CYCLES(16'h0008), .TRIM_PERIOD(16'h0008)) i_aoc_top (.*);
    aoc_rx_model i_aoc_rx_model (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Link clock offset so edges never line up
    initial begin
        link_clock = 1'b0;
        #7;
        forever #15 link_clock = ~link_clock;
    end
    // Range limits mixed into the random samples
    always @(negedge clock) begin
        // Ramp lets the two taps be checked against each other
        if (ramp) begin
            i_core_sample <= i_core_sample + 8'h01;
            q_core_sample <= q_core_sample + 8'h01;
        end else begin
            i_core_sample <= ($random(seed) & 3) == 0 ? 8'hFF : $random(seed);
            q_core_sample <= ($random(seed) & 3) == 0 ? 8'h00 : $random(seed);
        end
    end

    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_busy(logic lvl);
        n = 0;
        while (calibration_busy !== lvl && n < 200) begin
            cyc(1);
            n++;
        end
        if (n == 200) begin
            errors++;
            $display("[ERR] busy expected %b seen %b", lvl, calibration_busy);
            finish_test();
        end
    endtask
    task automatic cal_req();
        trim_request_pin = 1'b0;
        cyc(8);
        trim_request_pin = 1'b1;
        cyc(8);
    endtask
    // Entries 0..3 pin mode, 4..11 extended mode
    task automatic set_cfg(int k);
        int j;
        j = k - 4;
        extended_mode_n = (k < 4);
        edge_pin_floating = k[0];
        swing_level_pin = k[1];
        output_transition_edge_pin = k[1];
        dual_edge_pin_floating = k[0] ^ k[1];
        ddr_disable_n_bit = j[0];
        edge_or_demux_select = j[1];
        swing_level_bit = j[0];
        dual_edge_bit = j[2];
        q_input_select_bit = j[1];
    endtask
    // Packs {des, ddr, demux, reduced, q sampled, sync delay}
    function automatic logic [7:0] exp_cfg(int k);
        logic [2:0] j;
        logic       ddr, dm, des, red, sq;
        j = 3'(k - 4);
        ddr = (k < 4) ? k[0] : !j[0];
        dm = (k < 4) ? 1'b1 : (j[0] | !j[1]);
        des = (k < 4) ? (k[0] ^ k[1]) : j[2];
        red = (k < 4) ? !k[1] : !j[0];
        sq = (k < 4) ? 1'b0 : (j[2] & j[1]);
        return {des, ddr, dm, red, sq, (ddr & dm) ? 3'h4 : 3'h3};
    endfunction

    initial begin
        seed = 51;
        {errors, samples_checked} = 0;
        {resetn, q_sleep_pin, ramp} = '0;
        {clock_enable, sleep_pin, trim_request_pin} = 3'h7;
        output_transition_edge_pin = 1'b1;
        set_cfg(2);
        cyc(8);
        chk("reset bus", i_primary_bus, 8'h00);
        chk("reset strobe", {output_data_strobe, i_delayed_oe}, 8'h00);
        resetn = 1'b1;
        cyc(45);
        chk("sleep outs", {power_down_active, i_primary_oe, q_primary_oe,
            output_data_strobe, range_exceed_flag}, 8'h10);
        cyc(5);
        chk("cal held", calibration_busy, 8'h00);
        sleep_pin = 1'b0;
        ramp = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        for (int k = 0; k < 12; k++) begin
            set_cfg(k);
            cyc(50);
            e = exp_cfg(k);
            chk("config", {des_active, ddr_active, demux_active, reduced_swing,
                sampled_input_is_q, sync_delay_cycles}, e);
            chk("core edges", {i_core_on_rising, q_core_on_rising}, {1'b0, e[7]});
            chk("delayed oe", {i_delayed_oe, q_delayed_oe}, {2{e[5]}});
            m = 0;
            repeat (12) begin
                cyc(1);
                m += phase_trim_pulse;
            end
            chk("trim pulses", m != 0, e[7]);
            w = i_aoc_rx_model.word_q;
            chk("i taps", 8'(w[23:16] + 8'h01), w[7:0]);
            chk("q taps", 8'(w[31:24] + 8'h01), w[15:8]);
        end
        n = frames;
        cyc(40);
        chk("frames", frames > n, 8'h01);
        q_sleep_pin = 1'b1;
        cyc(6);
        cal_req();
        wait_busy(1'b1);
        wait_busy(1'b0);
        cyc(2);
        chk("q asleep", {q_cal_pending, q_core_powered, i_primary_oe}, 8'h05);
        q_sleep_pin = 1'b0;
        cyc(6);
        cal_req();
        wait_busy(1'b1);
        sleep_pin = 1'b1;
        cyc(6);
        chk("sleep deferred", power_down_active, 8'h00);
        wait_busy(1'b0);
        cyc(3);
        chk("sleep after cal", {power_down_active, q_cal_pending}, 8'h02);
        cal_req();
        m = 0;
        repeat (40) begin
            cyc(1);
            m += calibration_busy;
        end
        chk("cal in sleep", m, 8'h00);
        sleep_pin = 1'b0;
        // Frozen clock keeps the block asleep
        clock_enable = 1'b0;
        cyc(20);
        chk("frozen", {power_down_active, pipeline_valid}, 8'h02);
        clock_enable = 1'b1;
        cyc(5);
        chk("pipe invalid", pipeline_valid, 8'h00);
        cyc(30);
        chk("pipe valid", pipeline_valid, 8'h01);
        finish_test();
    end
endmodule
